// ---- asm_defines.svh ----
`ifndef ASM_DEFINES_SVH
`define ASM_DEFINES_SVH

// register offsets on the configuration port
`define ASM_ADDR_W            10
`define ASM_DATA_W            8
`define ASM_OFS_SUMMARY       10'h2C0
`define ASM_OFS_STATUS        10'h2C1
`define ASM_OFS_MASK          10'h2C2
`define ASM_OFS_LANE          10'h2C4
`define ASM_OFS_PIN_SEL       10'h2C6

// reset values
`define ASM_RST_STATUS        8'h3F
`define ASM_RST_MASK          8'h3F
`define ASM_RST_LANE          8'hFF
`define ASM_RST_PIN_SEL       1'h0

// field positions in the status and mask registers
`define ASM_BIT_FIFO          5
`define ASM_BIT_PLL           4
`define ASM_BIT_LINK          3
`define ASM_BIT_REALIGN       2
`define ASM_BIT_RSVD          1
`define ASM_BIT_CLK           0
`define ASM_STATUS_STORED     8'h3F
`define ASM_ALARM_SOURCES     8'h3D

`define ASM_NUM_LANES         8

`endif

// ---- asm_pkg.sv ----
`include "asm_defines.svh"

package asm_pkg;

    typedef logic [`ASM_ADDR_W-1:0] asm_addr_t;
    typedef logic [`ASM_DATA_W-1:0] asm_data_t;

    // one configuration-port access
    typedef struct packed {
        asm_addr_t addr;
        asm_data_t wdata;
        logic      wr;
        logic      rd;
    } asm_req_s;

    // fault conditions reported by the converter and link logic
    typedef struct packed {
        logic [`ASM_NUM_LANES-1:0] lane_fifo_err;
        logic [`ASM_NUM_LANES-1:0] lane_active;
        logic                      serializer_pll_locked;
        logic                      link_enable;
        logic                      link_mode_64b66b;
        logic                      data_phase_state;
        logic                      link_startup;
        logic                      link_realign;
        logic                      sysref_realign;
        logic                      divider_mismatch;
    } asm_events_s;

endpackage : asm_pkg

// ---- asm_alarm_unit.sv ----
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module asm_alarm_unit
    import asm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        soft_reset,
    input  wire asm_req_s    req,
    output logic [7:0]       rdata,
    input  wire asm_events_s evt,
    input  wire logic        cal_status_in,
    output logic             alarm_irq,
    output logic             calibration_status_pin
);

    // ------------------------------------------------------------------
    // register file state
    // ------------------------------------------------------------------
    asm_data_t                 status_q;
    asm_data_t                 status_d;
    asm_data_t                 mask_q;
    asm_data_t                 mask_d;
    logic [`ASM_NUM_LANES-1:0] lane_q;
    logic [`ASM_NUM_LANES-1:0] lane_d;
    logic                      pin_sel_q;
    logic                      pin_sel_d;
    asm_data_t                 rdata_q;
    asm_data_t                 rdata_d;

    logic                      wr_status;
    logic                      wr_mask;
    logic                      wr_lane;
    logic                      wr_pin_sel;
    logic [`ASM_NUM_LANES-1:0] lane_hit;
    logic [`ASM_NUM_LANES-1:0] lane_rst;
    logic                      fifo_set;
    logic                      pll_set;
    logic                      link_set;
    logic                      realign_set;
    logic                      clk_set;
    asm_data_t                 set_vec;
    logic                      summary;

    assign wr_status  = req.wr && (req.addr == `ASM_OFS_STATUS);
    assign wr_mask    = req.wr && (req.addr == `ASM_OFS_MASK);
    assign wr_lane    = req.wr && (req.addr == `ASM_OFS_LANE);
    assign wr_pin_sel = req.wr && (req.addr == `ASM_OFS_PIN_SEL);
    assign lane_rst   = `ASM_RST_LANE;

    // ------------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------------
    assign lane_hit    = evt.lane_fifo_err & evt.lane_active;
    assign fifo_set    = |lane_hit;
    assign pll_set     = !evt.serializer_pll_locked;

    // link flag follows the enable; with it low the flag is left alone
    always_comb begin
        link_set = 1'b0;
        if (evt.link_enable) begin
            if (!evt.link_mode_64b66b) begin
                link_set = !evt.data_phase_state;
            end else begin
                link_set = evt.link_startup || evt.link_realign;
            end
        end
    end

    assign realign_set = evt.sysref_realign;
    assign clk_set     = evt.divider_mismatch;

    always_comb begin
        set_vec                   = 8'h00;
        set_vec[`ASM_BIT_FIFO]    = fifo_set;
        set_vec[`ASM_BIT_PLL]     = pll_set;
        set_vec[`ASM_BIT_LINK]    = link_set;
        set_vec[`ASM_BIT_REALIGN] = realign_set;
        set_vec[`ASM_BIT_CLK]     = clk_set;
    end

    // ------------------------------------------------------------------
    // status and mask registers
    // ------------------------------------------------------------------
    always_comb begin
        status_d  = status_q;
        mask_d    = mask_q;
        pin_sel_d = pin_sel_q;
        if (soft_reset) begin
            status_d  = `ASM_RST_STATUS;
            mask_d    = `ASM_RST_MASK;
            pin_sel_d = `ASM_RST_PIN_SEL;
        end else begin
            if (wr_status) begin
                status_d = status_q & ~req.wdata;
            end
            // set beats a simultaneous clear
            status_d = (status_d | set_vec) & `ASM_STATUS_STORED;
            if (wr_mask) begin
                mask_d = req.wdata;
            end
            if (wr_pin_sel) begin
                pin_sel_d = req.wdata[0];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_q  <= `ASM_RST_STATUS;
            mask_q    <= `ASM_RST_MASK;
            pin_sel_q <= `ASM_RST_PIN_SEL;
        end else begin
            status_q  <= status_d;
            mask_q    <= mask_d;
            pin_sel_q <= pin_sel_d;
        end
    end

    // ------------------------------------------------------------------
    // per-lane FIFO flags
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `ASM_NUM_LANES; gi = gi + 1) begin : g_lane
            always_comb begin
                lane_d[gi] = lane_q[gi];
                if (soft_reset) begin
                    lane_d[gi] = lane_rst[gi];
                end else begin
                    if (wr_lane && req.wdata[gi]) begin
                        lane_d[gi] = 1'b0;
                    end
                    if (wr_status && req.wdata[`ASM_BIT_FIFO]) begin
                        lane_d[gi] = 1'b0;
                    end
                    if (lane_hit[gi]) begin
                        lane_d[gi] = 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lane_q <= `ASM_RST_LANE;
        end else begin
            lane_q <= lane_d;
        end
    end

    // ------------------------------------------------------------------
    // summary alarm and interrupt pin
    // ------------------------------------------------------------------
    assign summary = |(status_q & ~mask_q & `ASM_ALARM_SOURCES);
    assign alarm_irq = summary;
    assign calibration_status_pin = pin_sel_q ? summary
                                              : cal_status_in;

    // ------------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `ASM_OFS_SUMMARY: rdata_d = {7'h00, summary};
                `ASM_OFS_STATUS:  rdata_d = status_q;
                `ASM_OFS_MASK:    rdata_d = mask_q;
                `ASM_OFS_LANE:    rdata_d = lane_q;
                `ASM_OFS_PIN_SEL: rdata_d = {7'h00, pin_sel_q};
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_status_clear_all;
        wr_status && (req.wdata == 8'hFF) && !soft_reset;
    endsequence

    sequence s_quiet;
        (set_vec == 8'h00) && (lane_hit == 8'h00);
    endsequence

    property p_fifo_set;
        (lane_hit != 8'h00) && !soft_reset |=> status_q[`ASM_BIT_FIFO];
    endproperty
    a_fifo_set: assert property (p_fifo_set)
        else $error("fifo flag missed a lane fault");

    property p_pll_set;
        !evt.serializer_pll_locked && !soft_reset
            |=> status_q[`ASM_BIT_PLL];
    endproperty
    a_pll_set: assert property (p_pll_set)
        else $error("pll flag missed an unlock");

    property p_link_8b;
        evt.link_enable && !evt.link_mode_64b66b && !evt.data_phase_state
            && !soft_reset |=> status_q[`ASM_BIT_LINK];
    endproperty
    a_link_8b: assert property (p_link_8b)
        else $error("link flag missed a non-data state");

    property p_link_64b;
        evt.link_enable && evt.link_mode_64b66b
            && (evt.link_startup || evt.link_realign) && !soft_reset
            |=> status_q[`ASM_BIT_LINK];
    endproperty
    a_link_64b: assert property (p_link_64b)
        else $error("link flag missed a start-up or realignment");

    sequence s_link_off_clear;
        wr_status && req.wdata[`ASM_BIT_LINK] && !evt.link_enable
            && !soft_reset;
    endsequence

    property p_link_disabled;
        s_link_off_clear ##1 (!evt.link_enable && !soft_reset)
            |=> !status_q[`ASM_BIT_LINK];
    endproperty
    a_link_disabled: assert property (p_link_disabled)
        else $error("link flag set while link disabled");

    property p_realign_set;
        evt.sysref_realign && !soft_reset |=> status_q[`ASM_BIT_REALIGN];
    endproperty
    a_realign_set: assert property (p_realign_set)
        else $error("realignment flag missed");

    property p_clk_set;
        evt.divider_mismatch && !soft_reset |=> status_q[`ASM_BIT_CLK];
    endproperty
    a_clk_set: assert property (p_clk_set)
        else $error("clock flag missed a divider mismatch");

    property p_sticky;
        !wr_status && !soft_reset |=> ((status_q & $past(status_q))
            == $past(status_q));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status flag dropped without a clear");

    property p_clear;
        s_status_clear_all ##0 s_quiet |=> status_q == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("write of ones did not clear flags");

    property p_soft_reset;
        soft_reset |=> (status_q == `ASM_RST_STATUS)
            && (mask_q == `ASM_RST_MASK) && (lane_q == `ASM_RST_LANE);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore defaults");

    property p_mask_blocks;
        (mask_q == `ASM_RST_MASK) |-> !alarm_irq;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked flag reached the summary alarm");

    property p_summary_read;
        req.rd && (req.addr == `ASM_OFS_SUMMARY)
            |=> rdata == {7'h00, $past(alarm_irq)};
    endproperty
    a_summary_read: assert property (p_summary_read)
        else $error("summary read does not match alarm");

    property p_lane_clear_all;
        wr_status && req.wdata[`ASM_BIT_FIFO] && !soft_reset
            && (lane_hit == 8'h00) |=> lane_q == 8'h00;
    endproperty
    a_lane_clear_all: assert property (p_lane_clear_all)
        else $error("fifo flag clear did not clear lane flags");

    property p_set_wins;
        wr_status && req.wdata[`ASM_BIT_PLL] && !evt.serializer_pll_locked
            |=> status_q[`ASM_BIT_PLL];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear won over a same-cycle set");

    property p_pin_select;
        pin_sel_q |-> calibration_status_pin == alarm_irq;
    endproperty
    a_pin_select: assert property (p_pin_select)
        else $error("status pin not following the alarm");

    property p_pin_passthru;
        !pin_sel_q |-> calibration_status_pin == cal_status_in;
    endproperty
    a_pin_passthru: assert property (p_pin_passthru)
        else $error("status pin not showing calibration status");

    property p_lane_set;
        (lane_hit != 8'h00) && !soft_reset
            |=> ((lane_q & $past(lane_hit)) == $past(lane_hit));
    endproperty
    a_lane_set: assert property (p_lane_set)
        else $error("lane flag missed a lane fault");

    property p_lane_sticky;
        !wr_lane && !wr_status && !soft_reset
            |=> ((lane_q & $past(lane_q)) == $past(lane_q));
    endproperty
    a_lane_sticky: assert property (p_lane_sticky)
        else $error("lane flag dropped without a clear");

    property p_unmasked_alarm;
        (status_q[`ASM_BIT_FIFO] && !mask_q[`ASM_BIT_FIFO])
            || (status_q[`ASM_BIT_LINK] && !mask_q[`ASM_BIT_LINK])
            || (status_q[`ASM_BIT_CLK] && !mask_q[`ASM_BIT_CLK])
            |-> alarm_irq;
    endproperty
    a_unmasked_alarm: assert property (p_unmasked_alarm)
        else $error("unmasked flag did not raise the alarm");

    property p_no_source_quiet;
        ((status_q & ~mask_q & 8'hFD) == 8'h00) |-> !alarm_irq;
    endproperty
    a_no_source_quiet: assert property (p_no_source_quiet)
        else $error("alarm raised with no unmasked source");

endmodule : asm_alarm_unit

// ---- asm_alarm_unit_bench.sv ----
`timescale 1ns/1ps
`include "asm_defines.svh"

`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

module asm_alarm_unit_bench;
    import asm_pkg::*;

    logic        clk_sys;
    logic        rst;
    logic        soft_reset;
    asm_req_s    req;
    logic [7:0]  rdata;
    asm_events_s evt;
    logic        cal_status_in;
    logic        alarm_irq;
    logic        calibration_status_pin;
    int          failures;
    int          n_compared;
    logic [7:0]  d;
    logic [7:0]  exp_bit [7] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01,
                                 8'h08, 8'h08};

    asm_alarm_unit u_asm_alarm_unit (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .soft_reset            (soft_reset),
        .req                   (req),
        .rdata                 (rdata),
        .evt                   (evt),
        .cal_status_in         (cal_status_in),
        .alarm_irq             (alarm_irq),
        .calibration_status_pin(calibration_status_pin)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic wr_reg(input asm_addr_t a, input asm_data_t v);
        @(posedge clk_sys);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys);
        req <= '{a, 8'h00, 1'b0, 1'b0};
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input asm_addr_t a, output asm_data_t v);
        @(posedge clk_sys);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        req <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
        v = rdata;
    endtask : rd_reg

    // raise or drop one fault source
    task automatic set_src(input int i, input logic on);
        case (i)
            0: evt.lane_fifo_err <= on ? 8'h04 : 8'h00;
            1: evt.serializer_pll_locked <= !on;
            2: evt.data_phase_state <= !on;
            3: evt.sysref_realign <= on;
            4: evt.divider_mismatch <= on;
            5: begin
                evt.link_mode_64b66b <= 1'b1;
                evt.link_startup <= on;
            end
            default: evt.link_realign <= on;
        endcase
    endtask : set_src

    task automatic wrap_up;
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end

    initial begin
        failures = 0;
        n_compared = 0;
        rst = 1'b1;
        soft_reset = 1'b0;
        cal_status_in = 1'b1;
        req = '0;
        evt = '{8'h00, 8'hFF, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
                1'b0};
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // defaults after reset
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h3F)
        rd_reg(`ASM_OFS_MASK, d);
        `CHK(d, 8'h3F)
        rd_reg(`ASM_OFS_LANE, d);
        `CHK(d, 8'hFF)
        rd_reg(`ASM_OFS_SUMMARY, d);
        `CHK(d, 8'h00)
        `CHK(calibration_status_pin, 1'b1)
        rd_reg(10'h2C3, d);
        `CHK(d, 8'h00)
        // write-one clears, zero leaves alone
        wr_reg(`ASM_OFS_STATUS, 8'h01);
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h3E)
        wr_reg(`ASM_OFS_STATUS, 8'h00);
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h3E)
        // every source, recorded while masked, then unmasked
        for (int i = 0; i < 7; i++) begin
            wr_reg(`ASM_OFS_STATUS, 8'hFF);
            wr_reg(`ASM_OFS_LANE, 8'hFF);
            @(posedge clk_sys);
            set_src(i, 1'b1);
            @(posedge clk_sys);
            set_src(i, 1'b0);
            rd_reg(`ASM_OFS_STATUS, d);
            `CHK(d, exp_bit[i])
            `CHK(alarm_irq, 1'b0)
            if (i == 0) begin
                rd_reg(`ASM_OFS_LANE, d);
                `CHK(d, 8'h04)
            end
            wr_reg(`ASM_OFS_MASK, 8'h3F & ~exp_bit[i]);
            rd_reg(`ASM_OFS_SUMMARY, d);
            `CHK(d, 8'h01)
            `CHK(alarm_irq, 1'b1)
            wr_reg(`ASM_OFS_MASK, 8'h3F);
        end
        // clear while the fault persists keeps the flag
        wr_reg(`ASM_OFS_STATUS, 8'h3F);
        @(posedge clk_sys);
        evt.serializer_pll_locked <= 1'b0;
        wr_reg(`ASM_OFS_STATUS, 8'h10);
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h10)
        @(posedge clk_sys);
        evt.serializer_pll_locked <= 1'b1;
        wr_reg(`ASM_OFS_STATUS, 8'h10);
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h00)
        // per-lane flags, inactive lane ignored, global clear
        @(posedge clk_sys);
        evt.lane_active <= 8'h7F;
        evt.lane_fifo_err <= 8'h83;
        @(posedge clk_sys);
        evt.lane_fifo_err <= 8'h00;
        wr_reg(`ASM_OFS_LANE, 8'h01);
        rd_reg(`ASM_OFS_LANE, d);
        `CHK(d, 8'h02)
        wr_reg(`ASM_OFS_STATUS, 8'h20);
        rd_reg(`ASM_OFS_LANE, d);
        `CHK(d, 8'h00)
        // summary onto the status pin
        wr_reg(`ASM_OFS_PIN_SEL, 8'h01);
        rd_reg(`ASM_OFS_PIN_SEL, d);
        `CHK(d, 8'h01)
        `CHK(calibration_status_pin, 1'b0)
        @(posedge clk_sys);
        cal_status_in <= 1'b0;
        evt.divider_mismatch <= 1'b1;
        @(posedge clk_sys);
        evt.divider_mismatch <= 1'b0;
        wr_reg(`ASM_OFS_MASK, 8'h02);
        rd_reg(`ASM_OFS_MASK, d);
        `CHK(d, 8'h02)
        `CHK(calibration_status_pin, 1'b1)
        // link flag quiet while the link is off
        @(posedge clk_sys);
        evt.link_enable <= 1'b0;
        evt.link_mode_64b66b <= 1'b0;
        evt.data_phase_state <= 1'b0;
        wr_reg(`ASM_OFS_STATUS, 8'hFF);
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h00)
        @(posedge clk_sys);
        evt.link_enable <= 1'b1;
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h08)
        `CHK(alarm_irq, 1'b1)
        @(posedge clk_sys);
        evt.data_phase_state <= 1'b1;
        wr_reg(`ASM_OFS_STATUS, 8'hFF);
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h00)
        `CHK(alarm_irq, 1'b0)
        // soft reset restores defaults
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        rd_reg(`ASM_OFS_STATUS, d);
        `CHK(d, 8'h3F)
        rd_reg(`ASM_OFS_MASK, d);
        `CHK(d, 8'h3F)
        rd_reg(`ASM_OFS_LANE, d);
        `CHK(d, 8'hFF)
        `CHK(alarm_irq, 1'b0)
        wrap_up();
    end

endmodule : asm_alarm_unit_bench
